//--- hdl/gpi_port.sv
/*
  Port pins with direction, output data, per-pin interrupt detection and
  six pin-interrupt channels served by half-port assignment.
  Assumes pin inputs synchronous to clk_sys; writes arrive as one-cycle strobes.
*/
// Operation
// R01 - Per-pin direction, input or output
// R02 - Write-one bits modify, others untouched
// R03 - Per-pin mask enables pin interrupt
// R04 - Inputs sensed; outputs interrupt by software drive
// R05 - Level or edge; rising or both
// R06 - Edge or level with selectable polarity
// R07 - Detection independent of direction and outputs
// R08 - Six channels, up to 32 pins
// R09 - Half ports of eight assigned programmably
// R10 - Per-channel assign, mask, identify, clear registers
// R11 - Pin states, latches readable regardless mask
// R12 - Set and clear aliases per register
// R13 - Channel request while unmasked latch set
`timescale 1ns/10ps
`default_nettype none
`include "gpi_consts.svh"
module gpi_port #(
  parameter int PINS = `GPI_PINS,
  parameter int CHANNELS = `GPI_CHANNELS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire gpi_pkg::gpi_write_t wr,
  input wire logic [2:0] rd_channel,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] dir_out_ff,
  output logic [PINS-1:0] data_rd,
  output logic [PINS-1:0] pin_flag_ff,
  output gpi_pkg::gpi_chan_status_t chan_status,
  output logic [CHANNELS-1:0] pin_irq_channel
);
  localparam int HALVES = PINS / `GPI_HALF_WIDTH;

  // ************************************
  // Parameter checks
  // ************************************
  if (PINS != `GPI_PINS) begin : g_bad_pins
    $error("gpi_port: the port holds exactly 32 pins");
  end
  if (CHANNELS != `GPI_CHANNELS) begin : g_bad_channels
    $error("gpi_port: the interrupt unit serves exactly six channels");
  end
  if (HALVES * `GPI_HALF_WIDTH != PINS) begin : g_bad_halves
    $error("gpi_port: pins must fill whole half ports");
  end

  // ************************************
  // Write-one modify helper
  // ************************************
  function automatic logic [31:0] apply(input logic [31:0] cur, input gpi_pkg::gpi_action_t act,
                                        input logic [31:0] d);
    logic [31:0] r;
    r = cur;
    unique case (act)
      gpi_pkg::GPI_A_WRITE: r = d;
      gpi_pkg::GPI_A_SET: r = cur | d;
      gpi_pkg::GPI_A_CLEAR: r = cur & ~d;
      gpi_pkg::GPI_A_TOGGLE: r = cur ^ d;
    endcase
    return r;
  endfunction

  function automatic logic hit(input gpi_pkg::gpi_write_t w, input gpi_pkg::gpi_target_t t);
    return w.valid && w.target == t;
  endfunction

  // ************************************
  // Port configuration registers
  // ************************************
  logic [PINS-1:0] data_ff;
  logic [PINS-1:0] mask_ff;
  logic [PINS-1:0] edge_ff;
  logic [PINS-1:0] both_ff;
  logic [PINS-1:0] pol_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dir_out_ff <= `GPI_DIR_RST;
    end else if (hit(wr, gpi_pkg::GPI_T_DIR)) begin
      dir_out_ff <= apply(dir_out_ff, wr.action, wr.data); // [R01] [R02]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data_ff <= `GPI_DATA_RST;
    end else if (hit(wr, gpi_pkg::GPI_T_DATA)) begin
      data_ff <= apply(data_ff, wr.action, wr.data); // [R02]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_ff <= `GPI_MASK_RST;
    end else if (hit(wr, gpi_pkg::GPI_T_MASK)) begin
      mask_ff <= apply(mask_ff, wr.action, wr.data); // [R03] [R12]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      edge_ff <= `GPI_SENSE_RST;
    end else if (hit(wr, gpi_pkg::GPI_T_EDGE)) begin
      edge_ff <= apply(edge_ff, wr.action, wr.data); // [R05] [R12]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      both_ff <= `GPI_SENSE_RST;
    end else if (hit(wr, gpi_pkg::GPI_T_BOTH)) begin
      both_ff <= apply(both_ff, wr.action, wr.data); // [R05] [R12]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pol_ff <= `GPI_SENSE_RST;
    end else if (hit(wr, gpi_pkg::GPI_T_POL)) begin
      pol_ff <= apply(pol_ff, wr.action, wr.data); // [R06] [R12]
    end
  end

  // ************************************
  // Pin drive and readback
  // ************************************
  assign pin_out = data_ff;
  assign pin_oe = dir_out_ff; // [R01]
  always_comb begin
    data_rd = (dir_out_ff & data_ff) | (~dir_out_ff & pin_in);
  end

  // ************************************
  // Per-pin detection
  // ************************************
  logic [PINS-1:0] sense;
  logic [PINS-1:0] sense_prev_ff;
  logic [PINS-1:0] swtrig;
  logic [PINS-1:0] active;
  logic [PINS-1:0] evt;

  // Output pins see their driven value, so software raises them
  assign swtrig = hit(wr, gpi_pkg::GPI_T_SWTRIG) ? wr.data : '0;
  assign sense = ((dir_out_ff & data_ff) | (~dir_out_ff & pin_in)) ^ pol_ff; // [R04] [R06] [R07]

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sense_prev_ff <= '0;
    end else begin
      sense_prev_ff <= sense;
    end
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (edge_ff[i]) begin
        active[i] = both_ff[i] ? (sense[i] ^ sense_prev_ff[i]) : (sense[i] & ~sense_prev_ff[i]); // [R05]
      end else begin
        active[i] = sense[i]; // [R05]
      end
    end
    evt = (active | swtrig) & mask_ff; // [R03] [R04]
  end

  // ************************************
  // Channel half-port assignment
  // ************************************
  logic [`GPI_ASSIGN_BITS-1:0] assign_ff [HALVES];
  logic [PINS-1:0] ch_mask_ff [CHANNELS];
  logic [PINS-1:0] latch_ff [CHANNELS];
  logic [PINS-1:0] ch_pins [CHANNELS];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int h = 0; h < HALVES; h++) begin
        assign_ff[h] <= `GPI_ASSIGN_NONE;
      end
    end else if (hit(wr, gpi_pkg::GPI_T_CH_ASSIGN)) begin
      for (int h = 0; h < HALVES; h++) begin
        if (wr.data[h] && wr.action != gpi_pkg::GPI_A_CLEAR) begin
          assign_ff[h] <= wr.channel; // [R09] [R10]
        end else if (wr.data[h] && assign_ff[h] == wr.channel) begin
          assign_ff[h] <= `GPI_ASSIGN_NONE; // [R09] [R12]
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      for (int h = 0; h < HALVES; h++) begin
        ch_pins[c][h*`GPI_HALF_WIDTH +: `GPI_HALF_WIDTH] =
          {`GPI_HALF_WIDTH{assign_ff[h] == c[`GPI_ASSIGN_BITS-1:0]}}; // [R08] [R09]
      end
    end
  end

  // ************************************
  // Channel mask and latches
  // ************************************
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    gpi_chan #(
      .PINS(PINS),
      .CHAN(3'(c))
    ) u_chan (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .wr(wr),
      .evt(evt),
      .owned(ch_pins[c]),
      .mask_ff(ch_mask_ff[c]),
      .latch_ff(latch_ff[c])
    );
  end

  // ************************************
  // Requests and status
  // ************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_flag_ff <= '0;
    end else begin
      pin_flag_ff <= active; // [R07]
    end
  end

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      pin_irq_channel[c] = |(latch_ff[c] & ch_mask_ff[c]); // [R13]
    end
  end

  always_comb begin
    chan_status.pins = '0;
    chan_status.latch = '0;
    chan_status.request = '0;
    if (rd_channel < CHANNELS) begin
      chan_status.pins = data_rd & ch_pins[rd_channel]; // [R11]
      chan_status.latch = latch_ff[rd_channel]; // [R11]
      chan_status.request = latch_ff[rd_channel] & ch_mask_ff[rd_channel]; // [R10]
    end
  end
endmodule

// ************************************
// One pin-interrupt channel
// ************************************
module gpi_chan #(
  parameter int PINS = `GPI_PINS,
  parameter logic [2:0] CHAN = 3'h0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire gpi_pkg::gpi_write_t wr,
  input wire logic [PINS-1:0] evt,
  input wire logic [PINS-1:0] owned,
  output logic [PINS-1:0] mask_ff,
  output logic [PINS-1:0] latch_ff
);
  logic sel_mask;
  logic sel_latch;

  if (PINS > 32) begin : g_bad_pins
    $error("gpi_chan: a channel serves at most 32 pins");
  end

  function automatic logic [PINS-1:0] modify(input logic [PINS-1:0] cur, input gpi_pkg::gpi_action_t act,
                                             input logic [PINS-1:0] d);
    logic [PINS-1:0] r;
    r = cur;
    unique case (act)
      gpi_pkg::GPI_A_WRITE: r = d;
      gpi_pkg::GPI_A_SET: r = cur | d;
      gpi_pkg::GPI_A_CLEAR: r = cur & ~d;
      gpi_pkg::GPI_A_TOGGLE: r = cur ^ d;
    endcase
    return r;
  endfunction

  assign sel_mask = wr.valid && wr.target == gpi_pkg::GPI_T_CH_MASK && wr.channel == CHAN; // [R10]
  assign sel_latch = wr.valid && wr.target == gpi_pkg::GPI_T_CH_LATCH && wr.channel == CHAN; // [R10]

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_ff <= `GPI_MASK_RST;
    end else if (sel_mask) begin
      mask_ff <= modify(mask_ff, wr.action, wr.data[PINS-1:0]); // [R10] [R12]
    end
  end

  // Events gather regardless of channel mask; set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      latch_ff <= '0;
    end else if (sel_latch) begin
      latch_ff <= (modify(latch_ff, wr.action, wr.data[PINS-1:0]) | evt) & owned; // [R10] [R12]
    end else begin
      latch_ff <= (latch_ff | evt) & owned; // [R11]
    end
  end
endmodule
`default_nettype wire

//--- inc/gpi_consts.svh
/*
  Constants of the port and pin-interrupt block: widths, counts, reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef GPI_CONSTS_SVH
`define GPI_CONSTS_SVH
`define GPI_PINS 32
`define GPI_CHANNELS 6
`define GPI_HALF_WIDTH 8
`define GPI_HALF_PORTS 4
`define GPI_ASSIGN_BITS 3
`define GPI_DIR_RST 32'h0000_0000
`define GPI_DATA_RST 32'h0000_0000
`define GPI_MASK_RST 32'h0000_0000
`define GPI_SENSE_RST 32'h0000_0000
`define GPI_ASSIGN_NONE 3'h7
`endif

//--- inc/gpi_pkg.sv
/*
  Types of the port and pin-interrupt block.
  Assumes gpi_consts.svh on the include path.
*/
`include "gpi_consts.svh"
package gpi_pkg;
  // ************************************
  // Register targets and write actions
  // ************************************
  typedef enum logic [3:0] {
    GPI_T_DIR = 4'h0,
    GPI_T_DATA = 4'h1,
    GPI_T_MASK = 4'h2,
    GPI_T_EDGE = 4'h3,
    GPI_T_BOTH = 4'h4,
    GPI_T_POL = 4'h5,
    GPI_T_CH_MASK = 4'h6,
    GPI_T_CH_LATCH = 4'h7,
    GPI_T_CH_ASSIGN = 4'h8,
    GPI_T_SWTRIG = 4'h9
  } gpi_target_t;
  typedef enum logic [1:0] {
    GPI_A_WRITE = 2'h0,
    GPI_A_SET = 2'h1,
    GPI_A_CLEAR = 2'h2,
    GPI_A_TOGGLE = 2'h3
  } gpi_action_t;
  typedef struct packed {
    logic valid;
    gpi_target_t target;
    gpi_action_t action;
    logic [2:0] channel;
    logic [31:0] data;
  } gpi_write_t;
  typedef struct packed {
    logic [31:0] pins;
    logic [31:0] latch;
    logic [31:0] request;
  } gpi_chan_status_t;
endpackage

//--- sim/gpi_props.sv
/* Checker on the gpi_port ports.
   Bound to every gpi_port below. */
`timescale 1ns/10ps
`default_nettype none
module gpi_props #(parameter int PINS = 32, parameter int CHANNELS = 6) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire gpi_pkg::gpi_write_t wr,
  input wire logic [2:0] rd_channel,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] dir_out_ff,
  input wire logic [PINS-1:0] data_rd,
  input wire logic [PINS-1:0] pin_flag_ff,
  input wire gpi_pkg::gpi_chan_status_t chan_status,
  input wire logic [CHANNELS-1:0] pin_irq_channel
);
  // **********
  // Properties
  // **********
  logic [PINS-1:0] pd, pq;
  logic dw, mw;
  assign dw = wr.valid && wr.target == gpi_pkg::GPI_T_DIR;
  assign mw = wr.valid && wr.target == gpi_pkg::GPI_T_CH_MASK && wr.channel < 3'h6;
  always_ff @(posedge clk_sys) begin
    pd <= wr.data[PINS-1:0];
    pq <= dir_out_ff;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  dir_set_a: assert property (dw && wr.action == gpi_pkg::GPI_A_SET |=> dir_out_ff == (pq | pd))
    else $error("dir set");
  dir_clear_a: assert property (dw && wr.action == gpi_pkg::GPI_A_CLEAR |=> dir_out_ff == (pq & ~pd))
    else $error("dir clear");
  oe_dir_a: assert property (pin_oe == dir_out_ff) else $error("oe");
  rd_view_a: assert property (data_rd == ((pin_out & pin_oe) | (pin_in & ~pin_oe)))
    else $error("pin view");
  req_latch_a: assert property ((chan_status.request & ~chan_status.latch) == 0)
    else $error("request");
  irq_view_a: assert property (rd_channel < 3'h6 |-> pin_irq_channel[rd_channel] == |chan_status.request)
    else $error("irq");
  no_chan_a: assert property (rd_channel > 3'h5 |-> chan_status == '0) else $error("channel");
  mask_off_a: assert property (mw && wr.action == gpi_pkg::GPI_A_CLEAR && &wr.data
    |=> !pin_irq_channel[$past(wr.channel)]) else $error("mask");
  cover property ($rose(pin_irq_channel[2]));
  cover property ($fell(pin_irq_channel[2]));
  cover property (dw);
endmodule
bind gpi_port gpi_props #(.PINS(PINS), .CHANNELS(CHANNELS)) u_props (.clk_sys(clk_sys), .rstn(rstn), .wr(wr),
  .rd_channel(rd_channel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .dir_out_ff(dir_out_ff),
  .data_rd(data_rd), .pin_flag_ff(pin_flag_ff), .chan_status(chan_status), .pin_irq_channel(pin_irq_channel));
`default_nettype wire

//--- sim/gpi_board.sv
/* Board model of the port pins.
   Assumes pin_oe high where the port drives. */
`timescale 1ns/10ps
`default_nettype none
module gpi_board (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] board,
  output logic [31:0] pin_in
);
  // **********
  // Driven pins read back, others from board
  // **********
  assign pin_in = (pin_out & pin_oe) | (board & ~pin_oe);
endmodule
`default_nettype wire

//--- sim/gpi_port_bench.sv
/* Bench of gpi_port with the board model.
   Assumes gpi_pkg and gpi_consts.svh present. */
`timescale 1ns/10ps
`default_nettype none
module gpi_port_bench;
  // **********
  // Design, board and tasks
  // **********
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  gpi_pkg::gpi_write_t wr = '0;
  logic [2:0] rd_channel = 3'h2;
  logic [31:0] board = 32'h0000_0000;
  logic [31:0] pin_in, pin_out, pin_oe, dir_out_ff, data_rd, pin_flag_ff;
  gpi_pkg::gpi_chan_status_t chan_status;
  logic [5:0] pin_irq_channel;
  int n_fail = 0;
  int checks_done = 0;
  always #50 clk_sys = ~clk_sys;
  gpi_port DUT (.clk_sys(clk_sys), .rstn(rstn), .wr(wr), .rd_channel(rd_channel), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .dir_out_ff(dir_out_ff), .data_rd(data_rd), .pin_flag_ff(pin_flag_ff),
    .chan_status(chan_status), .pin_irq_channel(pin_irq_channel));
  gpi_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .board(board), .pin_in(pin_in));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(gpi_pkg::gpi_target_t t, gpi_pkg::gpi_action_t a, logic [31:0] d);
    @(posedge clk_sys);
    wr <= '{1'b1, t, a, 3'h2, d};
    @(posedge clk_sys);
    wr.valid <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic pins(logic [31:0] v);
    @(posedge clk_sys);
    board <= v;
    @(negedge clk_sys);
  endtask
  task automatic clr();
    put(gpi_pkg::GPI_T_CH_LATCH, gpi_pkg::GPI_A_CLEAR, 32'h8);
  endtask
  task automatic irq_is(logic lvl);
    int i;
    for (i = 0; i < 20 && pin_irq_channel[2] !== lvl; i++) @(negedge clk_sys);
    chk(pin_irq_channel[2], lvl);
    if (i == 20) end_of_test();
  endtask
  initial begin
    #5000000;
    n_fail++;
    end_of_test();
  end
  // **********
  // Sequence
  // **********
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk(dir_out_ff | pin_out | chan_status.latch, 32'h0);
    put(gpi_pkg::GPI_T_DIR, gpi_pkg::GPI_A_WRITE, 32'h0000_ffff);
    put(gpi_pkg::GPI_T_DIR, gpi_pkg::GPI_A_SET, 32'h00ff_0000);
    put(gpi_pkg::GPI_T_DIR, gpi_pkg::GPI_A_CLEAR, 32'h0000_000f);
    put(gpi_pkg::GPI_T_DIR, gpi_pkg::GPI_A_TOGGLE, 32'hf000_00ff);
    chk(dir_out_ff, 32'hf0ff_ff0f);
    chk(pin_oe, 32'hf0ff_ff0f);
    put(gpi_pkg::GPI_T_DATA, gpi_pkg::GPI_A_WRITE, 32'h0000_a5a5);
    pins(32'h5a5a_5a5a);
    chk(data_rd, 32'h0a00_a555);
    put(gpi_pkg::GPI_T_DATA, gpi_pkg::GPI_A_CLEAR, 32'h0000_0005);
    chk(pin_out, 32'h0000_a5a0);
    put(gpi_pkg::GPI_T_DIR, gpi_pkg::GPI_A_WRITE, 32'h0);
    pins(32'h0);
    put(gpi_pkg::GPI_T_CH_ASSIGN, gpi_pkg::GPI_A_SET, 32'h1);
    put(gpi_pkg::GPI_T_MASK, gpi_pkg::GPI_A_WRITE, 32'h0000_1018);
    put(gpi_pkg::GPI_T_EDGE, gpi_pkg::GPI_A_SET, 32'h8);
    put(gpi_pkg::GPI_T_CH_MASK, gpi_pkg::GPI_A_WRITE, 32'h8);
    irq_is(1'b0);
    pins(32'h8);
    irq_is(1'b1);
    chk(chan_status.latch, 32'h8);
    chk(chan_status.request, 32'h8);
    clr();
    irq_is(1'b0);
    put(gpi_pkg::GPI_T_EDGE, gpi_pkg::GPI_A_CLEAR, 32'h8);
    irq_is(1'b1);
    chk(pin_flag_ff, 32'h8);
    put(gpi_pkg::GPI_T_POL, gpi_pkg::GPI_A_SET, 32'h8);
    clr();
    irq_is(1'b0);
    pins(32'h0);
    irq_is(1'b1);
    put(gpi_pkg::GPI_T_CH_MASK, gpi_pkg::GPI_A_CLEAR, 32'hffff_ffff);
    irq_is(1'b0);
    chk(chan_status.latch, 32'h8);
    put(gpi_pkg::GPI_T_POL, gpi_pkg::GPI_A_CLEAR, 32'h8);
    put(gpi_pkg::GPI_T_BOTH, gpi_pkg::GPI_A_SET, 32'h8);
    put(gpi_pkg::GPI_T_EDGE, gpi_pkg::GPI_A_SET, 32'h8);
    put(gpi_pkg::GPI_T_CH_MASK, gpi_pkg::GPI_A_SET, 32'h8);
    clr();
    pins(32'h8);
    irq_is(1'b1);
    chk(chan_status.pins, 32'h8);
    clr();
    pins(32'h0);
    irq_is(1'b1);
    clr();
    put(gpi_pkg::GPI_T_SWTRIG, gpi_pkg::GPI_A_SET, 32'h0000_1010);
    irq_is(1'b0);
    chk(chan_status.latch, 32'h10);
    chk(pin_out, 32'h0000_a5a0);
    put(gpi_pkg::GPI_T_CH_LATCH, gpi_pkg::GPI_A_SET, 32'h0000_0108);
    irq_is(1'b1);
    chk(chan_status.latch, 32'h18);
    clr();
    irq_is(1'b0);
    put(gpi_pkg::GPI_T_CH_ASSIGN, gpi_pkg::GPI_A_CLEAR, 32'h1);
    @(negedge clk_sys);
    chk(chan_status.latch, 32'h0);
    @(posedge clk_sys);
    rd_channel <= 3'h6;
    @(negedge clk_sys);
    chk(chan_status.latch | chan_status.request, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
